// file: include/flic_pkg.sv
// ====================================================================
// five level interrupt controller constants
package flic_pkg;

    // source count and field widths
    localparam int FLIC_NSRC = 13;
    localparam int FLIC_LVW = 3;
    localparam int FLIC_IDW = 4;

    // natural order index of the first five sources
    localparam logic [3:0] FLIC_SRC_PF = 4'h0;
    localparam logic [3:0] FLIC_SRC_EXT0 = 4'h1;
    localparam logic [3:0] FLIC_SRC_TMR0 = 4'h2;
    localparam logic [3:0] FLIC_SRC_EXT1 = 4'h3;
    localparam logic [3:0] FLIC_SRC_TMR1 = 4'h4;

    // priority levels
    localparam logic [2:0] FLIC_LVL_PF = 3'h4;

    // vector address per natural order
    localparam logic [7:0] FLIC_VEC [FLIC_NSRC] = '{
        8'h33, 8'h03, 8'h0b, 8'h13, 8'h1b, 8'h23, 8'h2b,
        8'h3b, 8'h43, 8'h4b, 8'h53, 8'h5b, 8'h63};

    // register byte offsets
    localparam logic [7:0] FLIC_IRQ_ENABLE_OFF = 8'h00;
    localparam logic [7:0] FLIC_EXT_IRQ_ENABLE_OFF = 8'h04;
    localparam logic [7:0] FLIC_PRIO_LOW_OFF = 8'h08;
    localparam logic [7:0] FLIC_PRIO_HIGH_OFF = 8'h0c;
    localparam logic [7:0] FLIC_EXT_PRIO_LOW_OFF = 8'h10;
    localparam logic [7:0] FLIC_EXT_PRIO_HIGH_OFF = 8'h14;
    localparam logic [7:0] FLIC_TIMER_CONTROL_OFF = 8'h18;
    localparam logic [7:0] FLIC_EXT_FLAG_OFF = 8'h1c;
    localparam logic [7:0] FLIC_WATCHDOG_CONTROL_OFF = 8'h20;
    localparam logic [7:0] FLIC_PERIPH_FLAG_OFF = 8'h24;
    localparam logic [7:0] FLIC_IN_SERVICE_OFF = 8'h28;

    // field positions
    localparam int FLIC_GLOBAL_EN_BIT = 7;
    localparam int FLIC_EXT0_TYPE_BIT = 0;
    localparam int FLIC_EXT0_FLAG_BIT = 1;
    localparam int FLIC_EXT1_TYPE_BIT = 2;
    localparam int FLIC_EXT1_FLAG_BIT = 3;
    localparam int FLIC_TMR0_FLAG_BIT = 5;
    localparam int FLIC_TMR1_FLAG_BIT = 7;
    localparam int FLIC_EXT2_FLAG_BIT = 4;
    localparam int FLIC_WDOG_FLAG_BIT = 3;
    localparam int FLIC_PF_FLAG_BIT = 4;
    localparam int FLIC_PF_EN_BIT = 5;
    localparam int FLIC_SER0_RX_BIT = 0;
    localparam int FLIC_SER0_TX_BIT = 1;
    localparam int FLIC_SER1_RX_BIT = 2;
    localparam int FLIC_SER1_TX_BIT = 3;
    localparam int FLIC_TMR2_EXT_BIT = 6;
    localparam int FLIC_TMR2_OVF_BIT = 7;

    // reset values
    localparam logic [7:0] FLIC_REG_RST = 8'h00;
    localparam logic [4:0] FLIC_ISR_RST = 5'h00;

endpackage

// file: include/flic_arb_if.sv
`timescale 1ns/1ps
// ====================================================================
// request and winner carrier between control and arbiter
interface flic_arb_if;
    logic [12:0] req;
    logic [12:0][2:0] lvl;
    logic win_valid;
    logic [3:0] win_idx;
    logic [2:0] win_lvl;

    modport arb (input req, input lvl,
                 output win_valid, output win_idx, output win_lvl);
    modport ctl (output req, output lvl,
                 input win_valid, input win_idx, input win_lvl);
endinterface

// file: core/flic_arb.sv
`timescale 1ns/1ps
// ====================================================================
// level then natural order arbiter
module flic_arb
    import flic_pkg::*;
(
    // request side
    flic_arb_if.arb a
);

    // ================================================================
    // scan in natural order, replace only on a strictly higher level
    always_comb begin
        logic found;
        logic [3:0] idx;
        logic [2:0] lv;
        found = 1'b0;
        idx = 4'h0;
        lv = 3'h0;
        for (int i = 0; i < FLIC_NSRC; i++) begin
            if (a.req[i] && (!found || a.lvl[i] > lv)) begin
                found = 1'b1;
                idx = 4'(i);
                lv = a.lvl[i];
            end
        end
        a.win_valid = found;
        a.win_idx = idx;
        a.win_lvl = lv;
    end

endmodule // flic_arb

// file: core/flic_top.sv
`timescale 1ns/1ps
// Contract
// - thirteen sources are served, each with its own vector address.
// - non power-fail sources need their enable and the global enable.
// - with the global enable low only power-fail can be taken.
// - seven classic enables sit in bits 0-6, five more in bits 0-4.
// - power-fail is gated only by its own enable.
// - five levels 4..0 exist and level 4 belongs to power-fail.
// - other sources get level 0-3 from a low and a high bank bit.
// - an enabled power-fail request always wins.
// - equal levels resolve to the lowest natural order number.
// - vectors follow the fixed natural order table.
// - serial sources or rx and tx, timer 2 ors overflow and external.
// - timer 0 and 1 overflow flags clear when the core vectors.
// - edge ext0/1 flags clear on vectoring, level ones follow the pin.
// - flags set on their event whatever the enables say.
module flic_top
    import flic_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // external interrupt pins, active low
    input wire logic [5:0] ext_n_i,
    // peripheral event pulses
    input wire logic powerfail_i,
    input wire logic tmr0_ovf_i,
    input wire logic tmr1_ovf_i,
    input wire logic tmr2_ovf_i,
    input wire logic tmr2_ext_i,
    input wire logic ser0_rx_i,
    input wire logic ser0_tx_i,
    input wire logic ser1_rx_i,
    input wire logic ser1_tx_i,
    input wire logic watchdog_i,
    // processor core handshake
    input wire logic irq_ack_i,
    input wire logic reti_i,
    output logic irq_req_o,
    output logic [7:0] irq_vector_o,
    output logic [2:0] irq_level_o
);

    // ================================================================
    // state
    typedef struct packed {
        logic [7:0] irq_enable_reg;
        logic [7:0] ext_irq_enable_reg;
        logic [7:0] prio_low_bank;
        logic [7:0] prio_high_bank;
        logic [7:0] ext_prio_low_bank;
        logic [7:0] ext_prio_high_bank;
        logic [7:0] timer_control_reg;
        logic [7:0] ext_flag_reg;
        logic [7:0] watchdog_control_reg;
        logic [7:0] periph_flag_reg;
        logic [5:0] pin_prev;
        logic [4:0] in_service;
        logic req;
        logic [7:0] vec;
        logic [3:0] idx;
        logic [2:0] lvl;
        logic ack;
        logic [7:0] dat;
    } flic_state_s;

    flic_state_s s_q;
    flic_state_s s_d;

    flic_arb_if arb_bus ();

    // ================================================================
    // arbiter
    flic_arb u_arb (
        .a (arb_bus.arb)
    );

    // ================================================================
    // source flags, enables and levels from current state
    logic [12:0] src_flag;
    logic [12:0] src_en;
    logic [12:0][2:0] src_lvl;
    logic global_irq_enable;
    logic powerfail_enable;

    always_comb begin
        logic [7:0] tc;
        logic [7:0] pf;
        tc = s_q.timer_control_reg;
        pf = s_q.periph_flag_reg;
        global_irq_enable = s_q.irq_enable_reg[FLIC_GLOBAL_EN_BIT];
        powerfail_enable = s_q.watchdog_control_reg[FLIC_PF_EN_BIT];
        // natural order flag vector
        src_flag[0] = s_q.watchdog_control_reg[FLIC_PF_FLAG_BIT];
        src_flag[1] = tc[FLIC_EXT0_FLAG_BIT];
        src_flag[2] = tc[FLIC_TMR0_FLAG_BIT];
        src_flag[3] = tc[FLIC_EXT1_FLAG_BIT];
        src_flag[4] = tc[FLIC_TMR1_FLAG_BIT];
        src_flag[5] = pf[FLIC_SER0_RX_BIT] | pf[FLIC_SER0_TX_BIT];
        src_flag[6] = pf[FLIC_TMR2_OVF_BIT] | pf[FLIC_TMR2_EXT_BIT];
        src_flag[7] = pf[FLIC_SER1_RX_BIT] | pf[FLIC_SER1_TX_BIT];
        src_flag[11:8] = s_q.ext_flag_reg[7:4];
        src_flag[12] = s_q.watchdog_control_reg[FLIC_WDOG_FLAG_BIT];
        // enables and levels
        src_en[0] = powerfail_enable;
        src_lvl[0] = FLIC_LVL_PF;
        for (int i = 1; i < FLIC_NSRC; i++) begin
            if (i < 8) begin
                src_en[i] = s_q.irq_enable_reg[i-1] &
                    global_irq_enable;
                src_lvl[i] = {1'b0, s_q.prio_high_bank[i-1],
                    s_q.prio_low_bank[i-1]};
            end else begin
                src_en[i] = s_q.ext_irq_enable_reg[i-8] &
                    global_irq_enable;
                src_lvl[i] = {1'b0, s_q.ext_prio_high_bank[i-8],
                    s_q.ext_prio_low_bank[i-8]};
            end
        end
    end

    // requests into the arbiter
    assign arb_bus.req = src_flag & src_en;
    assign arb_bus.lvl = src_lvl;

    // ================================================================
    // bus decode
    logic bus_hit;
    logic bus_wr;
    logic [7:0] wdat;
    logic [7:0] rdat;

    assign bus_hit = wb_cyc_i & wb_stb_i & ~s_q.ack;
    assign bus_wr = bus_hit & wb_we_i & wb_sel_i[0];
    assign wdat = wb_dat_i[7:0];

    // read mux, unmapped reads zero
    always_comb begin
        unique case (wb_adr_i)
            FLIC_IRQ_ENABLE_OFF: rdat = s_q.irq_enable_reg;
            FLIC_EXT_IRQ_ENABLE_OFF: rdat = {3'h0,
                s_q.ext_irq_enable_reg[4:0]};
            FLIC_PRIO_LOW_OFF: rdat = s_q.prio_low_bank;
            FLIC_PRIO_HIGH_OFF: rdat = s_q.prio_high_bank;
            FLIC_EXT_PRIO_LOW_OFF: rdat = {3'h0,
                s_q.ext_prio_low_bank[4:0]};
            FLIC_EXT_PRIO_HIGH_OFF: rdat = {3'h0,
                s_q.ext_prio_high_bank[4:0]};
            FLIC_TIMER_CONTROL_OFF: rdat = s_q.timer_control_reg;
            FLIC_EXT_FLAG_OFF: rdat = s_q.ext_flag_reg;
            FLIC_WATCHDOG_CONTROL_OFF: rdat = s_q.watchdog_control_reg;
            FLIC_PERIPH_FLAG_OFF: rdat = s_q.periph_flag_reg;
            FLIC_IN_SERVICE_OFF: rdat = {3'h0, s_q.in_service};
            default: rdat = 8'h00;
        endcase
    end

    // ================================================================
    // in-service level tracking
    logic [2:0] cur_lvl;
    logic [2:0] ret_lvl;
    logic busy;
    logic [4:0] isr_after_ret;

    always_comb begin
        cur_lvl = 3'h0;
        for (int i = 0; i < 5; i++) begin
            if (s_q.in_service[i]) begin
                cur_lvl = 3'(i);
            end
        end
        busy = |s_q.in_service;
        ret_lvl = cur_lvl;
        isr_after_ret = s_q.in_service;
        if (reti_i && busy) begin
            isr_after_ret[ret_lvl] = 1'b0; // pop the running level
        end
    end

    // ================================================================
    // pin edges, falling edge of an active low pin
    logic [5:0] pin_fall;
    assign pin_fall = s_q.pin_prev & ~ext_n_i;

    // ================================================================
    // next state
    always_comb begin
        logic [7:0] tc;
        logic [7:0] xf;
        logic [7:0] wd;
        logic [7:0] pf;
        logic edge0;
        logic edge1;
        s_d = s_q;
        s_d.ack = 1'b0;
        s_d.pin_prev = ext_n_i;

        // register writes
        if (bus_wr) begin
            unique case (wb_adr_i)
                FLIC_IRQ_ENABLE_OFF: s_d.irq_enable_reg = wdat;
                FLIC_EXT_IRQ_ENABLE_OFF: s_d.ext_irq_enable_reg = wdat;
                FLIC_PRIO_LOW_OFF: s_d.prio_low_bank = wdat;
                FLIC_PRIO_HIGH_OFF: s_d.prio_high_bank = wdat;
                FLIC_EXT_PRIO_LOW_OFF: s_d.ext_prio_low_bank = wdat;
                FLIC_EXT_PRIO_HIGH_OFF: s_d.ext_prio_high_bank = wdat;
                FLIC_TIMER_CONTROL_OFF: s_d.timer_control_reg = wdat;
                FLIC_EXT_FLAG_OFF: s_d.ext_flag_reg = wdat;
                FLIC_WATCHDOG_CONTROL_OFF:
                    s_d.watchdog_control_reg = wdat;
                FLIC_PERIPH_FLAG_OFF: s_d.periph_flag_reg = wdat;
                default: s_d.ack = s_d.ack; // read-only or unmapped
            endcase
        end

        // bus answer one cycle after the request
        if (bus_hit) begin
            s_d.ack = 1'b1;
            s_d.dat = rdat;
        end

        tc = s_d.timer_control_reg;
        xf = s_d.ext_flag_reg;
        wd = s_d.watchdog_control_reg;
        pf = s_d.periph_flag_reg;
        edge0 = s_q.timer_control_reg[FLIC_EXT0_TYPE_BIT];
        edge1 = s_q.timer_control_reg[FLIC_EXT1_TYPE_BIT];

        // return then vectoring on the in-service stack
        s_d.in_service = isr_after_ret;
        if (irq_ack_i) begin
            s_d.in_service[s_q.lvl] = 1'b1;
            unique case (s_q.idx)
                FLIC_SRC_TMR0: tc[FLIC_TMR0_FLAG_BIT] = 1'b0;
                FLIC_SRC_TMR1: tc[FLIC_TMR1_FLAG_BIT] = 1'b0;
                FLIC_SRC_EXT0: begin
                    if (edge0) begin
                        tc[FLIC_EXT0_FLAG_BIT] = 1'b0;
                    end
                end
                FLIC_SRC_EXT1: begin
                    if (edge1) begin
                        tc[FLIC_EXT1_FLAG_BIT] = 1'b0;
                    end
                end
                default: tc = tc; // others cleared by software
            endcase
        end

        // hardware sets win over any clear in the same cycle
        if (tmr0_ovf_i) begin
            tc[FLIC_TMR0_FLAG_BIT] = 1'b1;
        end
        if (tmr1_ovf_i) begin
            tc[FLIC_TMR1_FLAG_BIT] = 1'b1;
        end
        if (edge0) begin
            tc[FLIC_EXT0_FLAG_BIT] = tc[FLIC_EXT0_FLAG_BIT] | pin_fall[0];
        end else begin
            tc[FLIC_EXT0_FLAG_BIT] = ~ext_n_i[0];
        end
        if (edge1) begin
            tc[FLIC_EXT1_FLAG_BIT] = tc[FLIC_EXT1_FLAG_BIT] | pin_fall[1];
        end else begin
            tc[FLIC_EXT1_FLAG_BIT] = ~ext_n_i[1];
        end
        xf[7:4] = xf[7:4] | pin_fall[5:2];
        if (powerfail_i) begin
            wd[FLIC_PF_FLAG_BIT] = 1'b1;
        end
        if (watchdog_i) begin
            wd[FLIC_WDOG_FLAG_BIT] = 1'b1;
        end
        if (ser0_rx_i) begin
            pf[FLIC_SER0_RX_BIT] = 1'b1;
        end
        if (ser0_tx_i) begin
            pf[FLIC_SER0_TX_BIT] = 1'b1;
        end
        if (ser1_rx_i) begin
            pf[FLIC_SER1_RX_BIT] = 1'b1;
        end
        if (ser1_tx_i) begin
            pf[FLIC_SER1_TX_BIT] = 1'b1;
        end
        if (tmr2_ovf_i) begin
            pf[FLIC_TMR2_OVF_BIT] = 1'b1;
        end
        if (tmr2_ext_i) begin
            pf[FLIC_TMR2_EXT_BIT] = 1'b1;
        end
        s_d.timer_control_reg = tc;
        s_d.ext_flag_reg = xf;
        s_d.watchdog_control_reg = wd;
        s_d.periph_flag_reg = pf;

        // request only above the running level
        s_d.req = arb_bus.win_valid &&
            (!busy || arb_bus.win_lvl > cur_lvl);
        s_d.vec = FLIC_VEC[arb_bus.win_idx];
        s_d.idx = arb_bus.win_idx;
        s_d.lvl = arb_bus.win_lvl;
    end

    // ================================================================
    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s_q <= '0;
            s_q.irq_enable_reg <= FLIC_REG_RST;
            s_q.in_service <= FLIC_ISR_RST;
            s_q.pin_prev <= 6'h3f;
        end else begin
            s_q <= s_d;
        end
    end

    // ================================================================
    // outputs
    assign wb_ack_o = s_q.ack;
    assign wb_dat_o = {24'h000000, s_q.dat};
    assign irq_req_o = s_q.req;
    assign irq_vector_o = s_q.vec;
    assign irq_level_o = s_q.lvl;

endmodule // flic_top

// file: dv/flic_props.sv
`timescale 1ns/1ps
// ====================================================================
// port level checks of the interrupt controller
module flic_props (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // core handshake
    input wire logic irq_req_o,
    input wire logic [7:0] irq_vector_o,
    input wire logic [2:0] irq_level_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // ====================================================================
    // bus answer
    chk_ack_answer: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acked next cycle");
    chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_ack_cause: assert property (
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    chk_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper read data not zero");
    chk_unmapped_zero: assert property (
        wb_ack_o && $past(!wb_we_i && wb_adr_i == 8'h2c)
        |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    chk_isr_width: assert property (
        wb_ack_o && $past(!wb_we_i && wb_adr_i == 8'h28)
        |-> wb_dat_o[7:5] == 3'h0)
        else $error("in-service beyond five levels");

    // ====================================================================
    // vector and level
    chk_vec_known: assert property (
        irq_req_o |-> irq_vector_o inside {
        8'h33, 8'h03, 8'h0b, 8'h13, 8'h1b, 8'h23, 8'h2b,
        8'h3b, 8'h43, 8'h4b, 8'h53, 8'h5b, 8'h63})
        else $error("vector outside table");
    chk_pf_level: assert property (
        irq_req_o && irq_vector_o == 8'h33 |-> irq_level_o == 3'h4)
        else $error("power-fail not at top level");
    chk_sw_level: assert property (
        irq_req_o && irq_vector_o != 8'h33 |-> irq_level_o <= 3'h3)
        else $error("software level above three");
endmodule // flic_props

bind flic_top flic_props u_flic_props (
    .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_dat_o, .wb_ack_o, .irq_req_o, .irq_vector_o, .irq_level_o
);

// file: dv/flic_core_model.sv
`timescale 1ns/1ps
// ====================================================================
// processor core stand-in: vectors on request, returns on command
module flic_core_model (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bench control
    input wire logic en_i,
    input wire logic slow_i,
    input wire logic ret_i,
    // controller side
    input wire logic irq_req_i,
    input wire logic [7:0] irq_vector_i,
    output logic irq_ack_o,
    output logic reti_o,
    // record of vectoring
    output logic [7:0] taken_o,
    output logic [7:0] cnt_o
);
    logic [2:0] gap_q;

    // ack once, then wait out the request lag
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_ack_o <= 1'b0;
            reti_o <= 1'b0;
            taken_o <= 8'h00;
            cnt_o <= 8'h00;
            gap_q <= 3'h0;
        end else begin
            irq_ack_o <= 1'b0;
            reti_o <= ret_i;
            if (irq_ack_o) begin
                taken_o <= irq_vector_i;
                cnt_o <= cnt_o + 8'h01;
            end
            if (gap_q != 3'h0) begin
                gap_q <= gap_q - 3'h1;
            end else if (en_i && irq_req_i && !irq_ack_o) begin
                irq_ack_o <= 1'b1;
                gap_q <= slow_i ? 3'h6 : 3'h3;
            end
        end
    end
endmodule // flic_core_model

// file: dv/flic_bench.sv
`timescale 1ns/1ps
// ====================================================================
// self-checking bench for the interrupt controller
module flic_bench;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hf;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
    logic wb_ack_o, irq_ack_i, reti_i, irq_req_o, ev_v;
    logic [7:0] irq_vector_o, taken, cnt, q, ew;
    logic [2:0] irq_level_o, alt, el;
    logic [9:0] ev = 10'h000;
    logic [5:0] ext_n_i = 6'h3f;
    logic en = 1'b0, slow = 1'b0, ret = 1'b0, pf = 1'b0;
    logic [12:0] s;
    logic [7:0] rg [6];
    logic [7:0] vt [13] = '{8'h33, 8'h03, 8'h0b, 8'h13, 8'h1b, 8'h23,
        8'h2b, 8'h3b, 8'h43, 8'h4b, 8'h53, 8'h5b, 8'h63};
    int seed = 32'h9216;
    int fail_count = 0, n_checks = 0;

    // clock
    always #12.5 clk_i = ~clk_i;

    // device and core stand-in
    flic_top u_flic_top (
        .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .ext_n_i,
        .powerfail_i(ev[0]), .tmr0_ovf_i(ev[1]), .tmr1_ovf_i(ev[2]),
        .tmr2_ovf_i(ev[3]), .tmr2_ext_i(ev[4]), .ser0_rx_i(ev[5]),
        .ser0_tx_i(ev[6]), .ser1_rx_i(ev[7]), .ser1_tx_i(ev[8]),
        .watchdog_i(ev[9]), .irq_ack_i, .reti_i, .irq_req_o,
        .irq_vector_o, .irq_level_o
    );
    flic_core_model u_flic_core_model (
        .clk_i, .rst_i, .en_i(en), .slow_i(slow), .ret_i(ret),
        .irq_req_i(irq_req_o), .irq_vector_i(irq_vector_o),
        .irq_ack_o(irq_ack_i), .reti_o(reti_i), .taken_o(taken),
        .cnt_o(cnt)
    );

    // ====================================================================
    // helpers
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] sv, e, input string nm);
        n_checks++;
        if (sv !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, e, sv);
        end
    endtask

    task automatic limit(input int n, lim);
        if (n >= lim) begin
            fail_count++;
            finish_test();
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    // one classic cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, d);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= {24'h0, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        q = wb_dat_o[7:0];
        limit(n, 20);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, d);
        wb(1'b1, a, d);
    endtask

    task automatic rc(input logic [7:0] a, e);
        wb(1'b0, a, 8'h00);
        chk(q, e, "register");
    endtask

    task automatic setall;
        for (int j = 0; j < 6; j++) begin
            wr(8'(4 * j), rg[j]);
            // extended registers store all eight bits but read back only bits 0-4
            rc(8'(4 * j), (j == 1 || j > 3) ? rg[j] & 8'h1f : rg[j]);
        end
    endtask

    // one-cycle events for a set of sources
    task automatic pulse(input logic [12:0] m, input logic [2:0] a);
        @(posedge clk_i);
        ev <= {m[12], m[7] & a[1], m[7] & ~a[1], m[5] & a[0],
            m[5] & ~a[0], m[6] & a[2], m[6] & ~a[2], m[4], m[2], m[0]};
        ext_n_i <= ~{m[11:8], m[3], m[1]};
        @(posedge clk_i);
        ev <= 10'h000;
        ext_n_i <= 6'h3f;
    endtask

    // wait for the core to vector and compare the vector
    task automatic take(input logic [7:0] e);
        logic [7:0] c0;
        int n;
        c0 = cnt;
        n = 0;
        while (cnt === c0 && n < 40) begin
            @(posedge clk_i);
            n++;
        end
        limit(n, 40);
        chk(taken, e, "vector");
    endtask

    // expected winner: highest level, then lowest natural order
    function automatic logic [7:0] win(input logic [12:0] m,
            output logic [2:0] l, output logic v);
        logic [2:0] lv;
        logic e;
        win = 8'h00;
        l = 3'h0;
        v = 1'b0;
        for (int i = 0; i < 13; i++) begin
            if (i == 0) begin
                e = pf;
                lv = 3'h4;
            end else if (i < 8) begin
                e = rg[0][7] & rg[0][i-1];
                lv = {1'b0, rg[3][i-1], rg[2][i-1]};
            end else begin
                e = rg[0][7] & rg[1][i-8];
                lv = {1'b0, rg[5][i-8], rg[4][i-8]};
            end
            if (m[i] && e && (!v || lv > l)) begin
                v = 1'b1;
                l = lv;
                win = vt[i];
            end
        end
    endfunction

    // ====================================================================
    // main sequence
    initial begin
        tick(4);
        rst_i <= 1'b0;
        // reset values, in-service and unmapped hole
        for (int a = 0; a <= 44; a += 4) rc(8'(a), 8'h00);
        // refused writes
        wr(8'h28, 8'hff);
        wb_sel_i <= 4'he;
        wr(8'h00, 8'hff);
        wb_sel_i <= 4'hf;
        rc(8'h28, 8'h00);
        rc(8'h00, 8'h00);
        // level mode flag follows the pin
        ext_n_i <= 6'h3e;
        tick(3);
        rc(8'h18, 8'h02);
        ext_n_i <= 6'h3f;
        tick(3);
        rc(8'h18, 8'h00);
        // flag sets while masked; both enables needed
        pulse(13'h0004, 3'h0);
        tick(3);
        rc(8'h18, 8'h20);
        for (int k = 0; k < 2; k++) begin
            wr(8'h00, k ? 8'h80 : 8'h02);
            tick(3);
            chk(irq_req_o, 8'h00, "request");
        end
        wr(8'h00, 8'h82);
        en <= 1'b1;
        take(8'h0b);
        rc(8'h18, 8'h00);
        rc(8'h28, 8'h01);
        en <= 1'b0;
        ret <= 1'b1;
        @(posedge clk_i);
        ret <= 1'b0;
        tick(3);
        rc(8'h28, 8'h00);
        // edge mode ext0 flag clears on vectoring
        wr(8'h18, 8'h01);
        wr(8'h00, 8'h81);
        en <= 1'b1;
        pulse(13'h0002, 3'h0);
        take(8'h03);
        rc(8'h18, 8'h01);
        en <= 1'b0;
        ret <= 1'b1;
        @(posedge clk_i);
        ret <= 1'b0;
        tick(3);
        // random enables, levels and event sets
        wr(8'h18, 8'h05);
        for (int k = 0; k < 24; k++) begin
            for (int j = 0; j < 6; j++) rg[j] = 8'($random(seed));
            pf = 1'($random(seed));
            slow <= 1'($random(seed));
            setall();
            wr(8'h20, {2'h0, pf, 5'h00});
            s = 13'($random(seed));
            alt = 3'($random(seed));
            pulse(s, alt);
            tick(3);
            ew = win(s, el, ev_v);
            chk(irq_req_o, ev_v, "request");
            if (ev_v) begin
                chk(irq_vector_o, ew, "winner");
                chk(irq_level_o, el, "level");
            end
            wr(8'h18, 8'h05);
            wr(8'h1c, 8'h00);
            wr(8'h20, {2'h0, pf, 5'h00});
            wr(8'h24, 8'h00);
        end
        // nesting: tmr1 and ser0 at level 1, tmr0 at 0
        rg = '{8'h9a, 8'h00, 8'h18, 8'h00, 8'h00, 8'h00};
        setall();
        wr(8'h20, 8'h00);
        en <= 1'b1;
        pulse(13'h0004, 3'h0);
        take(8'h0b);
        pulse(13'h0010, 3'h0);
        take(8'h1b);
        rc(8'h18, 8'h05);
        pulse(13'h0020, 3'h0);
        tick(6);
        chk(irq_req_o, 8'h00, "request");
        rc(8'h28, 8'h03);
        ret <= 1'b1;
        @(posedge clk_i);
        ret <= 1'b0;
        take(8'h23);
        rc(8'h28, 8'h03);
        // power-fail with the global enable cleared
        wr(8'h00, 8'h00);
        wr(8'h20, 8'h20);
        pulse(13'h0001, 3'h0);
        take(8'h33);
        rc(8'h28, 8'h13);
        rc(8'h20, 8'h30);
        finish_test();
    end
endmodule // flic_bench
